// *** inc/slp_map.vh ***
// Constants for the sample lane packer: modes, variants, frame layout
`ifndef SLP_MAP_VH
`define SLP_MAP_VH
// ==================================================
// Link format codes
`define SLP_FMT_MODE0 1'h0
`define SLP_FMT_MODE1 1'h1
// ==================================================
// Part variants
`define SLP_VAR_SINGLE 2'h0
`define SLP_VAR_DUAL 2'h1
`define SLP_VAR_QUAD 2'h2
// ==================================================
// Frame layout
`define SLP_SAMPLE_W 9
`define SLP_SLOT_PAD 3'h0
`define SLP_TAIL 4'h0
`define SLP_MODE0_OCTETS 8
`define SLP_MODE1_OCTETS 2
`define SLP_LANES 8
`define SLP_FRAME_W 64
`define SLP_MODE0_SLOTS 5
// ==================================================
// Lane enable masks
`define SLP_EN_M0_QUAD 8'hFF
`define SLP_EN_M0_DUAL 8'h0F
`define SLP_EN_M0_SINGLE 8'h03
`define SLP_EN_M1_QUAD 8'h3F
`define SLP_EN_M1_DUAL 8'h07
`define SLP_EN_M1_SINGLE 8'h03
`endif

// *** core/slp_pair_packer.v ***
// Mode 1 packing of one channel pair onto three 16-bit lane frames
`include "slp_map.vh"
module slp_pair_packer (
  input wire [8:0] x0_i,
  input wire [8:0] x1_i,
  input wire [8:0] y0_i,
  input wire [8:0] y1_i,
  input wire y_en_i,
  output wire [15:0] lane0_o,
  output wire [15:0] lane1_o,
  output wire [15:0] lane2_o
);
  wire [8:0] y0_g;
  wire [8:0] y1_g;
  // Missing second channel sends zero octet
  assign y0_g = y_en_i ? y0_i : 9'h000;
  assign y1_g = y_en_i ? y1_i : 9'h000;
  assign lane0_o = {x0_i, `SLP_SLOT_PAD, x1_i[8:5]};
  assign lane1_o = {x1_i[4:0], `SLP_SLOT_PAD, y0_g[8:1]};
  assign lane2_o = {y0_g[0], `SLP_SLOT_PAD, y1_g, `SLP_SLOT_PAD};
endmodule

// *** core/slp_lane_packer.v ***
// Transport packer placing 9-bit samples into lane frames for link formats 0 and 1
// How it works
// - Format 0 uses 8, 4 or 2 lanes for quad, dual, single parts.
// - Format 0 lane frame: five 12-bit slots of sample plus three zeros, then tail.
// - Each channel uses a lane pair: even samples low lane, odd samples high lane.
// - Channel A lanes 0-1, B 2-3, C 4-5, D 6-7 on quad part only.
// - Format 1 uses 6, 3 or 2 lanes with two-octet lane frames.
// - Format 1 lane 0: A0 with three zeros, then A1 bits 8 to 5.
// - Lane 1: A1 bits 4-0, three zeros, B0 bits 8-1, zero on single part.
// - Lane 2: B0 bit 0, three zeros, B1 with three zeros.
// - Quad part repeats that split for C and D on lanes 3 to 5.
// - Tail nibbles and padding are always sent as zero.
// - Samples are placed MSB first, LSB last.
// - Lowest lanes are used, higher lanes powered down.
`include "slp_map.vh"
module slp_lane_packer (
  input wire CLK_I,
  input wire RST_I,
  input wire LINK_FORMAT_SELECT_I,
  input wire [1:0] PART_VARIANT_I,
  input wire FRAME_VALID_I,
  input wire [89:0] SAMPLES_A_I,
  input wire [89:0] SAMPLES_B_I,
  input wire [89:0] SAMPLES_C_I,
  input wire [89:0] SAMPLES_D_I,
  output reg [511:0] LANE_DATA_O,
  output reg [7:0] LANE_ENABLE_O,
  output reg FRAME_VALID_O
);
  // ==================================================
  // Samples: index n sits at bits [9n+8:9n]; format 1 uses n=0,1 only
  wire quad;
  wire multi;
  reg [7:0] en_d;
  reg [511:0] data_d;
  wire [63:0] m0_lane [0:7];
  wire [15:0] m1_lane [0:5];
  wire [359:0] all_ch;
  integer k;

  assign quad = (PART_VARIANT_I == `SLP_VAR_QUAD);
  assign multi = (PART_VARIANT_I != `SLP_VAR_SINGLE);
  assign all_ch = {SAMPLES_D_I, SAMPLES_C_I, SAMPLES_B_I, SAMPLES_A_I};

  // ==================================================
  // Format 0 lane frames
  genvar l;
  genvar s;
  generate
    for (l = 0; l < 8; l = l + 1) begin : g_m0
      wire [59:0] slots;
      for (s = 0; s < 5; s = s + 1) begin : g_slot
        // Lane l: channel l/2, sample 2s + l%2
        assign slots[59-12*s -: 12] =
          {all_ch[90*(l/2) + 9*(2*s + (l%2)) +: 9], `SLP_SLOT_PAD};
      end
      assign m0_lane[l] = {slots, `SLP_TAIL};
    end
  endgenerate

  // ==================================================
  // Format 1 lane frames
  slp_pair_packer u_ab (
    .x0_i(SAMPLES_A_I[8:0]),
    .x1_i(SAMPLES_A_I[17:9]),
    .y0_i(SAMPLES_B_I[8:0]),
    .y1_i(SAMPLES_B_I[17:9]),
    .y_en_i(multi),
    .lane0_o(m1_lane[0]),
    .lane1_o(m1_lane[1]),
    .lane2_o(m1_lane[2])
  );
  slp_pair_packer u_cd (
    .x0_i(SAMPLES_C_I[8:0]),
    .x1_i(SAMPLES_C_I[17:9]),
    .y0_i(SAMPLES_D_I[8:0]),
    .y1_i(SAMPLES_D_I[17:9]),
    .y_en_i(1'h1),
    .lane0_o(m1_lane[3]),
    .lane1_o(m1_lane[4]),
    .lane2_o(m1_lane[5])
  );

  // ==================================================
  // Lane selection and power-down
  always @* begin
    if (LINK_FORMAT_SELECT_I == `SLP_FMT_MODE0) begin
      case (PART_VARIANT_I)
        `SLP_VAR_QUAD: en_d = `SLP_EN_M0_QUAD;
        `SLP_VAR_DUAL: en_d = `SLP_EN_M0_DUAL;
        default: en_d = `SLP_EN_M0_SINGLE;
      endcase
    end else begin
      case (PART_VARIANT_I)
        `SLP_VAR_QUAD: en_d = `SLP_EN_M1_QUAD;
        `SLP_VAR_DUAL: en_d = `SLP_EN_M1_DUAL;
        default: en_d = `SLP_EN_M1_SINGLE;
      endcase
    end
  end

  // Format 1 frame is left-justified in each 64-bit lane word, rest zero
  always @* begin
    data_d = 512'h0;
    for (k = 0; k < 8; k = k + 1) begin
      if (en_d[k]) begin
        if (LINK_FORMAT_SELECT_I == `SLP_FMT_MODE0) begin
          data_d[64*k +: 64] = m0_lane[k];
        end else if (k < 6) begin
          data_d[64*k +: 64] = {m1_lane[k], 48'h0};
        end
      end
    end
  end

  // ==================================================
  // One register stage for every lane, so frames stay aligned
  always @(posedge CLK_I) begin
    if (RST_I) begin
      LANE_DATA_O <= 512'h0;
      LANE_ENABLE_O <= 8'h00;
      FRAME_VALID_O <= 1'b0;
    end else begin
      LANE_DATA_O <= FRAME_VALID_I ? data_d : 512'h0;
      LANE_ENABLE_O <= en_d;
      FRAME_VALID_O <= FRAME_VALID_I;
    end
  end
endmodule

// *** sim/slp_lane_packer_monitor.sv ***
// Port assertions for the sample lane packer
module slp_lane_packer_monitor (
  input logic CLK_I,
  input logic RST_I,
  input logic LINK_FORMAT_SELECT_I,
  input logic [1:0] PART_VARIANT_I,
  input logic FRAME_VALID_I,
  input logic [511:0] LANE_DATA_O,
  input logic [7:0] LANE_ENABLE_O,
  input logic FRAME_VALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  chk_valid_delay: assert property (!$past(RST_I) |-> FRAME_VALID_O == $past(FRAME_VALID_I))
    else $error("frame valid not one cycle late");
  chk_idle_zero: assert property (!FRAME_VALID_O |-> LANE_DATA_O == 512'h0)
    else $error("lane data not zero without frame");
  chk_tail_zero: assert property ((LANE_DATA_O & {8{64'hF}}) == 512'h0)
    else $error("tail nibble not zero");
  chk_pad_fmt0: assert property (!$past(RST_I) && !$past(LINK_FORMAT_SELECT_I)
    |-> (LANE_DATA_O & {8{64'h007007007007007F}}) == 512'h0)
    else $error("format 0 padding not zero");
  chk_pad_fmt1: assert property ($past(LINK_FORMAT_SELECT_I) |-> (LANE_DATA_O & {{128{1'b1}},
    {2{64'h7007FFFFFFFFFFFF, 64'h0700FFFFFFFFFFFF, 64'h0070FFFFFFFFFFFF}}}) == 512'h0)
    else $error("format 1 padding not zero");
  chk_mask_quad: assert property (!$past(RST_I) && $past(PART_VARIANT_I) == 2'h2
    |-> LANE_ENABLE_O == ($past(LINK_FORMAT_SELECT_I) ? 8'h3F : 8'hFF))
    else $error("quad lane mask wrong");
  chk_mask_dual: assert property (!$past(RST_I) && $past(PART_VARIANT_I) == 2'h1
    |-> LANE_ENABLE_O == ($past(LINK_FORMAT_SELECT_I) ? 8'h07 : 8'h0F))
    else $error("dual lane mask wrong");
  chk_mask_single: assert property (!$past(RST_I) && $past(PART_VARIANT_I) == 2'h0
    |-> LANE_ENABLE_O == 8'h03)
    else $error("single lane mask wrong");
endmodule
bind slp_lane_packer slp_lane_packer_monitor i_mon (.CLK_I, .RST_I, .LINK_FORMAT_SELECT_I, .PART_VARIANT_I,
  .FRAME_VALID_I, .LANE_DATA_O, .LANE_ENABLE_O, .FRAME_VALID_O);

// *** sim/slp_rx_model.sv ***
// Receiver model rejoining channel A samples from the lanes
module slp_rx_model (
  input logic fmt_i,
  input logic [511:0] lanes_i,
  output logic [89:0] chan_a_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Receiver taps the lowest lanes only
  always_comb begin
    for (int n = 0; n < 10; n++) chan_a_o[9*n+:9] = lanes_i[64*(n%2)+55-12*(n/2)+:9];
    if (fmt_i) chan_a_o = {72'h0, lanes_i[51:48], lanes_i[127:123], lanes_i[63:55]};
  end
endmodule

// *** sim/test_slp_lane_packer.sv ***
// Random and corner-case bench for the sample lane packer
module test_slp_lane_packer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, fmt = 0, val = 0, fs, vls, fv, rs;
  logic [1:0] pv = 0, ps;
  logic [89:0] smp [4] = '{default: '0};
  logic [89:0] rx_a;
  logic [359:0] sv;
  logic [511:0] ld;
  logic [7:0] le;
  logic [31:0] seed = 32'hF275, r;
  int miscompares = 0, n_compared = 0;
  slp_lane_packer i_slp_lane_packer (.CLK_I(clk), .RST_I(rst), .LINK_FORMAT_SELECT_I(fmt), .PART_VARIANT_I(pv),
    .FRAME_VALID_I(val), .SAMPLES_A_I(smp[0]), .SAMPLES_B_I(smp[1]), .SAMPLES_C_I(smp[2]),
    .SAMPLES_D_I(smp[3]), .LANE_DATA_O(ld), .LANE_ENABLE_O(le), .FRAME_VALID_O(fv));
  slp_rx_model i_slp_rx_model (.fmt_i(fs), .lanes_i(ld), .chan_a_o(rx_a));
  // ==================================================
  // Expectations
  function automatic logic [31:0] rn();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] em(input logic f, input logic [1:0] v);
    return v == 2'h2 ? (f ? 8'h3F : 8'hFF) : v == 2'h1 ? (f ? 8'h07 : 8'h0F) : 8'h03;
  endfunction
  function automatic logic [511:0] pk(input logic f, ok, input logic [1:0] v, input logic [359:0] s);
    logic [511:0] q;
    logic [47:0] w;
    logic [7:0] m;
    q = '0;
    m = em(f, v);
    for (int k = 0; k < 8; k++) for (int n = 0; n < 5; n++)
      q[64*k+52-12*n+:12] = {s[90*(k/2)+18*n+9*(k%2)+:9], 3'h0};
    if (f) q = '0;
    for (int p = 0; p < 2 && f; p++) begin
      w = {s[180*p+:9], 3'h0, s[180*p+9+:9], 3'h0, v ? s[180*p+90+:9] : 9'h0, 3'h0, s[180*p+99+:9], 3'h0};
      for (int j = 0; j < 3; j++) q[64*(3*p+j)+48+:16] = w[32-16*j+:16];
    end
    for (int k = 0; k < 8; k++) if (!m[k]) q[64*k+:64] = '0;
    return ok ? q : '0;
  endfunction
  task automatic cmp(input logic [511:0] g, e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==================================================
  // Stimulus: first eight frames all ones to expose padding, one reset mid-run
  initial forever #20 clk = ~clk;
  initial begin
    #24000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      {rs, fs, ps, vls, sv} = {rst, fmt, pv, val, smp[3], smp[2], smp[1], smp[0]};
      rst <= (i == 200);
      r = rn();
      fmt <= i < 8 ? i[0] : r[0];
      pv <= i < 8 ? i[2:1] : r[2:1];
      val <= i < 8 || r[3];
      for (int c = 0; c < 4; c++) smp[c] <= i < 8 ? '1 : 90'({rn(), rn(), rn()});
      @(negedge clk);
      if (i > 0) begin
        cmp(ld, pk(fs, vls && !rs, ps, sv));
        cmp(512'(le), rs ? 512'h0 : 512'(em(fs, ps)));
        cmp(512'(fv), 512'(vls && !rs));
        if (vls && !rs) cmp(512'(rx_a), fs ? 512'(sv[17:0]) : 512'(sv[89:0]));
      end
    end
    wrap_up();
  end
endmodule
